// *** core/aqs_defs.svh ***
/*
 * Constants of the two-queue converter scheduler: register offsets,
 * field positions, mode codes and table sizes.
 * Assumes it is included by the package and the bench, by its bare name.
 */
`ifndef AQS_DEFS_SVH
`define AQS_DEFS_SVH

// ****************************************************
// Register offsets (byte addresses on APB)
// ****************************************************
`define AQS_ADDR_CTRL 12'h000
`define AQS_ADDR_SWTRIG 12'h004
`define AQS_ADDR_STATUS 12'h008
`define AQS_PAGE_CCW 4'h1
`define AQS_PAGE_RESULT 4'h2

// ****************************************************
// Control register fields
// ****************************************************
`define AQS_CTRL_MODE1_LSB 0
`define AQS_CTRL_MODE2_LSB 2
`define AQS_CTRL_RESUME_BIT 4
`define AQS_CTRL_BQ2_LSB 8

// ****************************************************
// Status register fields
// ****************************************************
`define AQS_ST_CF1_BIT 0
`define AQS_ST_CF2_BIT 1
`define AQS_ST_PF1_BIT 2
`define AQS_ST_PF2_BIT 3
`define AQS_ST_TOR1_BIT 4
`define AQS_ST_TOR2_BIT 5
`define AQS_ST_QS_LSB 8
`define AQS_ST_Q2STATE_LSB 12
`define AQS_ST_PTR_LSB 16

// ****************************************************
// Mode codes, table geometry, reset values
// ****************************************************
`define AQS_MODE_DISABLED 2'h0
`define AQS_MODE_RUN 2'h1
`define AQS_EOQ_CHAN 6'h3f
`define AQS_TABLE_DEPTH 64
`define AQS_RESULT_WIDTH 10
`define AQS_RST_VALUE 32'h0000_0000

`endif

// *** core/aqs_pkg.sv ***
/*
 * Types of the two-queue converter scheduler: queue and engine states
 * and the packed state record of the scheduler.
 * Assumes aqs_defs.svh sits beside it.
 */
package aqs_pkg;
`include "aqs_defs.svh"

   // Condition of one queue
   typedef enum logic [2:0] {
      QS_IDLE,
      QS_ACTIVE,
      QS_PAUSED,
      QS_PENDING,
      QS_SUSPENDED
   } aqs_qstate_type;

   // Command word engine
   typedef enum logic [1:0] {
      ENG_IDLE,
      ENG_FETCH,
      ENG_CONV
   } aqs_eng_type;

   // Every flip-flop of the scheduler
   typedef struct packed {
      logic [1:0] mode1;
      logic [1:0] mode2;
      logic resume;
      logic [6:0] bq2;
      logic cf1;
      logic cf2;
      logic pf1;
      logic pf2;
      logic tor1;
      logic tor2;
      aqs_qstate_type q1;
      aqs_qstate_type q2;
      logic [6:0] ptr1;
      logic [6:0] ptr2;
      aqs_eng_type eng;
      logic cur_q2;
      logic cur_pause;
      logic [63:0][6:0] conversion_command_word;
      logic [63:0][9:0] result;
      logic [5:0] conv_channel;
      logic conv_start;
      logic conv_abort;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [3:0] qs;
   } aqs_state_type;

endpackage : aqs_pkg

// *** core/aqs_scheduler.sv ***
/*
 * Two-queue scheduler for one shared converter, with APB registers,
 * the command word table and the result memory.
 * Assumes an APB master on pclk, trigger pins synchronous to pclk and
 * a converter that answers each conv_start with one conv_done pulse.
 */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Busy queue trigger sets overrun, else ignored
// - After completion, next trigger restarts queue
// - Premature triggers in subqueues flag overrun too
// - Queue 2 trigger during queue 1 pends
// - Extra queue 2 triggers flag overrun
// - Queue 1 trigger aborts and suspends queue 2
// - Resume off: suspended queue 2 restarts
// - Resume on: continue at aborted word
// - Trigger while suspended flags queue 2 overrun
// - Freeze finishes conversion, then stops
// - After freeze, continue with next word
// - Triggers during freeze are not captured
// - Pending and suspended queue 2 survive freeze
// - End code in word: complete, no conversion
// - Start pointer 63: convert, then complete
// - Start pointer zero ends queue 1 immediately
// - Start pointer beyond table ends queue 2
// - Pause before end: both flags, idle
// - Pause with end on same word: end wins
// - Disabled queue ignores triggers, stays inactive
// - Reserved mode behaves as disabled
// - Both disabled: table access without waits
// - Simultaneous triggers: queue 1 runs, 2 pends
// - Pause word: convert, pause flag, wait trigger
// - Four-bit field reports both queue states
module aqs_scheduler
   import aqs_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Trigger sources
   input wire logic ext_trig1,
   input wire logic ext_trig2,
   input wire logic freeze,
   // Converter core
   output logic conv_start,
   output logic conv_abort,
   output logic [5:0] conv_channel,
   input wire logic conv_done,
   input wire logic [9:0] conv_result,
   // Status
   output logic [3:0] queue_state_field
);

   // ****************************************************
   // State record
   // ****************************************************
   aqs_state_type s_q; // Registered state
   aqs_state_type s_d; // Next state
   logic t1; // Accepted queue 1 trigger
   logic t2; // Accepted queue 2 trigger
   logic suspend_ev; // Queue 2 suspended this cycle

   // End of queue seen at word p for the given queue
   function automatic logic eoq_at(input aqs_state_type s,
                                   input logic q2, input logic [6:0] p);
      logic hit;
      hit = p[6];
      if (!q2 && p == s.bq2)
         hit = 1'b1;
      if (!p[6] && s.conversion_command_word[p[5:0]][5:0] == `AQS_EOQ_CHAN)
         hit = 1'b1;
      return hit;
   endfunction : eoq_at

   // Two-bit code per queue; pending and suspended share a code
   function automatic logic [1:0] qcode(input aqs_qstate_type q);
      logic [1:0] c;
      c = 2'h3;
      if (q == QS_IDLE)
         c = 2'h0;
      else if (q == QS_ACTIVE)
         c = 2'h1;
      else if (q == QS_PAUSED)
         c = 2'h2;
      return c;
   endfunction : qcode

   // ****************************************************
   // Next-state logic
   // ****************************************************
   // Order matters: bus writes, then engine, then triggers, so that
   // hardware sets win over software clears and triggers win last.
   always_comb
   begin
      logic acc;
      logic tbl;
      logic res;
      logic cq_act;
      logic [6:0] cptr;
      logic [6:0] nptr;
      logic [31:0] rd;
      logic hit;
      s_d = s_q;
      s_d.conv_start = 1'b0;
      s_d.conv_abort = 1'b0;
      suspend_ev = 1'b0;
      acc = psel & penable & s_q.pready;
      tbl = paddr[11:8] == `AQS_PAGE_CCW;
      res = paddr[11:8] == `AQS_PAGE_RESULT;
      cptr = s_q.cur_q2 ? s_q.ptr2 : s_q.ptr1;
      nptr = 7'(cptr + 7'h01);
      cq_act = s_q.cur_q2 ? (s_q.q2 == QS_ACTIVE) : (s_q.q1 == QS_ACTIVE);
      rd = `AQS_RST_VALUE;
      hit = 1'b1;
      // Read mux; unmapped addresses answer with an error
      if (paddr == `AQS_ADDR_CTRL)
         rd = {17'h0, s_q.bq2, 3'h0, s_q.resume, s_q.mode2, s_q.mode1};
      else if (paddr == `AQS_ADDR_STATUS)
         rd = {9'h0, (s_q.cur_q2 ? s_q.ptr2 : s_q.ptr1), 1'b0, s_q.q2,
               s_q.qs, 2'h0, s_q.tor2, s_q.tor1, s_q.pf2, s_q.pf1,
               s_q.cf2, s_q.cf1};
      else if (tbl)
         rd = {25'h0, s_q.conversion_command_word[paddr[7:2]]};
      else if (res)
         rd = {22'h0, s_q.result[paddr[7:2]]};
      else if (paddr != `AQS_ADDR_SWTRIG)
         hit = 1'b0;
      // Ready: memory pages wait one cycle only while the engine runs
      if (psel & ~penable)
      begin
         s_d.pready = ~((tbl | res) & (s_q.eng != ENG_IDLE));
      end
      else if (psel & penable & ~s_q.pready)
         s_d.pready = 1'b1;
      else
         s_d.pready = 1'b0;
      if (s_d.pready)
      begin
         s_d.prdata = rd;
         s_d.pslverr = ~hit;
      end
      // Register writes take effect on the completing edge
      if (acc & pwrite)
      begin
         if (paddr == `AQS_ADDR_CTRL)
         begin
            s_d.mode1 = pwdata[`AQS_CTRL_MODE1_LSB +: 2];
            s_d.mode2 = pwdata[`AQS_CTRL_MODE2_LSB +: 2];
            s_d.resume = pwdata[`AQS_CTRL_RESUME_BIT];
            s_d.bq2 = pwdata[`AQS_CTRL_BQ2_LSB +: 7];
         end
         else if (paddr == `AQS_ADDR_STATUS)
         begin
            // Write one to clear; engine sets below still win
            s_d.cf1 = s_q.cf1 & ~pwdata[`AQS_ST_CF1_BIT];
            s_d.cf2 = s_q.cf2 & ~pwdata[`AQS_ST_CF2_BIT];
            s_d.pf1 = s_q.pf1 & ~pwdata[`AQS_ST_PF1_BIT];
            s_d.pf2 = s_q.pf2 & ~pwdata[`AQS_ST_PF2_BIT];
            s_d.tor1 = s_q.tor1 & ~pwdata[`AQS_ST_TOR1_BIT];
            s_d.tor2 = s_q.tor2 & ~pwdata[`AQS_ST_TOR2_BIT];
         end
         else if (tbl)
            s_d.conversion_command_word[paddr[7:2]] = pwdata[6:0];
      end

      // Engine: one word fetched, then converted
      case (s_q.eng)
         ENG_IDLE:
         begin
            // Queue 1 first; queue 2 only while queue 1 is not active
            if (s_q.q1 == QS_ACTIVE)
            begin
               s_d.eng = ENG_FETCH;
               s_d.cur_q2 = 1'b0;
            end
            else if (s_q.q2 == QS_ACTIVE || s_q.q2 == QS_PENDING ||
                     s_q.q2 == QS_SUSPENDED)
            begin
               s_d.q2 = QS_ACTIVE;
               s_d.eng = ENG_FETCH;
               s_d.cur_q2 = 1'b1;
            end
         end
         ENG_FETCH:
         begin
            if (!cq_act)
               s_d.eng = ENG_IDLE;
            else if (!freeze)
            begin
               if (eoq_at(s_q, s_q.cur_q2, cptr))
               begin
                  s_d.eng = ENG_IDLE;
                  if (s_q.cur_q2)
                  begin
                     s_d.cf2 = 1'b1;
                     s_d.q2 = QS_IDLE;
                  end
                  else
                  begin
                     s_d.cf1 = 1'b1;
                     s_d.q1 = QS_IDLE;
                  end
               end
               else
               begin
                  s_d.conv_start = 1'b1;
                  s_d.conv_channel = s_q.conversion_command_word[cptr[5:0]][5:0];
                  s_d.cur_pause = s_q.conversion_command_word[cptr[5:0]][6];
                  s_d.eng = ENG_CONV;
               end
            end
         end
         ENG_CONV:
         begin
            if (!cq_act)
            begin
               s_d.conv_abort = 1'b1;
               s_d.eng = ENG_IDLE;
            end
            else if (conv_done)
            begin
               s_d.result[cptr[5:0]] = conv_result;
               if (s_q.cur_q2)
                  s_d.ptr2 = nptr;
               else
                  s_d.ptr1 = nptr;
               s_d.eng = ENG_FETCH;
               if (s_q.cur_pause)
               begin
                  s_d.eng = ENG_IDLE;
                  if (s_q.cur_q2)
                  begin
                     s_d.pf2 = 1'b1;
                     s_d.q2 = QS_PAUSED;
                  end
                  else
                  begin
                     s_d.pf1 = 1'b1;
                     s_d.q1 = QS_PAUSED;
                  end
                  if (eoq_at(s_q, s_q.cur_q2, nptr))
                  begin
                     if (s_q.cur_q2)
                     begin
                        s_d.cf2 = 1'b1;
                        s_d.q2 = QS_IDLE;
                     end
                     else
                     begin
                        s_d.cf1 = 1'b1;
                        s_d.q1 = QS_IDLE;
                     end
                  end
               end
            end
         end
         default:
            s_d.eng = ENG_IDLE;
      endcase

      // Queue 1 trigger
      if (t1)
      begin
         if (s_q.q1 == QS_ACTIVE)
            s_d.tor1 = 1'b1;
         else
         begin
            if (s_q.q1 == QS_IDLE)
               s_d.ptr1 = 7'h00;
            s_d.q1 = QS_ACTIVE;
            if (s_d.q2 == QS_ACTIVE)
            begin
               suspend_ev = 1'b1;
               s_d.q2 = QS_SUSPENDED;
               if (!s_q.resume)
                  s_d.ptr2 = s_q.bq2;
            end
         end
      end
      // Queue 2 trigger
      if (t2)
      begin
         if (s_q.q2 == QS_ACTIVE || s_q.q2 == QS_SUSPENDED ||
             s_q.q2 == QS_PENDING)
            s_d.tor2 = 1'b1;
         else
         begin
            if (s_q.q2 == QS_IDLE)
               s_d.ptr2 = s_q.bq2;
            s_d.q2 = (t1 || s_q.q1 == QS_ACTIVE) ? QS_PENDING : QS_ACTIVE;
         end
      end
      if (s_q.mode1 != `AQS_MODE_RUN)
         s_d.q1 = QS_IDLE;
      if (s_q.mode2 != `AQS_MODE_RUN)
         s_d.q2 = QS_IDLE;
      s_d.qs = {qcode(s_d.q1), qcode(s_d.q2)};
   end

   // ****************************************************
   // Trigger acceptance
   // ****************************************************
   // Software and pin triggers merge; freeze and a non-run mode drop them
   always_comb
   begin
      logic sw_hit;
      sw_hit = psel & penable & s_q.pready & pwrite &
               (paddr == `AQS_ADDR_SWTRIG);
      t1 = (ext_trig1 | (sw_hit & pwdata[0])) & ~freeze &
           (s_q.mode1 == `AQS_MODE_RUN);
      t2 = (ext_trig2 | (sw_hit & pwdata[1])) & ~freeze &
           (s_q.mode2 == `AQS_MODE_RUN);
   end

   // ****************************************************
   // State register
   // ****************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // Outputs straight from the state register
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign conv_start = s_q.conv_start;
   assign conv_abort = s_q.conv_abort;
   assign conv_channel = s_q.conv_channel;
   assign queue_state_field = s_q.qs;

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_busy_overrun: assert property (
      t1 && s_q.q1 == QS_ACTIVE |=> s_q.tor1)
      else $error("queue 1 overrun not flagged");
   chk_q2_pending: assert property (
      t2 && !t1 && s_q.q1 == QS_ACTIVE && s_q.q2 == QS_IDLE
      && s_q.mode2 == `AQS_MODE_RUN |=> s_q.q2 == QS_PENDING)
      else $error("queue 2 trigger not held pending");
   chk_abort_conv: assert property (
      t1 && s_q.q1 != QS_ACTIVE && s_q.eng == ENG_CONV && s_q.cur_q2
      && s_q.q2 == QS_ACTIVE && !conv_done
      |=> s_q.q2 == QS_SUSPENDED ##1 conv_abort)
      else $error("queue 2 conversion not aborted");
   chk_restart_ptr: assert property (
      suspend_ev && !s_q.resume |=> s_q.ptr2 == $past(s_q.bq2))
      else $error("suspended queue 2 not rewound");
   chk_resume_ptr: assert property (
      suspend_ev && s_q.resume && !conv_done |=>
      s_q.ptr2 == $past(s_q.ptr2))
      else $error("suspended queue 2 lost its word");
   chk_freeze_hold: assert property (
      s_q.eng == ENG_FETCH && freeze |=> !conv_start)
      else $error("word fetched during freeze");
   chk_eoq_noconv: assert property (
      s_q.eng == ENG_FETCH && !freeze && eoq_at(s_q, s_q.cur_q2,
      s_q.cur_q2 ? s_q.ptr2 : s_q.ptr1) |=> !conv_start
      && s_q.eng == ENG_IDLE)
      else $error("end of queue converted");
   chk_disabled_idle: assert property (
      s_q.mode1 != `AQS_MODE_RUN |=> s_q.q1 == QS_IDLE)
      else $error("disabled queue 1 not idle");
   chk_nowait_idle: assert property (
      psel && !penable && s_q.eng == ENG_IDLE |=> pready)
      else $error("wait state while engine idle");

   cov_suspend: cover property (suspend_ev);
   cov_pause_eoq: cover property (s_q.pf1 && s_q.cf1);
   cov_pending_run: cover property (
      s_q.q2 == QS_PENDING ##[1:200] s_q.q2 == QS_ACTIVE);

endmodule : aqs_scheduler

`default_nettype wire

// *** testbench/aqs_conv_model.sv ***
/*
 * Behavioural model of the shared converter core behind the scheduler.
 * Assumes one conversion at a time; the bench sets its length in cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module aqs_conv_model
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Scheduler side
   input wire logic conv_start,
   input wire logic conv_abort,
   input wire logic [5:0] conv_channel,
   output logic conv_done,
   output logic [9:0] conv_result,
   // Conversion length, prompt or slow
   input wire logic [7:0] lat
);
   logic busy_q; // Conversion running
   logic [7:0] cnt_q; // Cycles left
   logic [5:0] ch_q; // Channel being converted
   // One done per start and none after an abort; the result
   // toggles while not valid so a stale value never looks good
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
         ch_q <= 6'h00;
         conv_done <= 1'b0;
         conv_result <= 10'h155;
      end
      else
      begin
         conv_done <= 1'b0;
         conv_result <= ~conv_result;
         if (conv_abort)
            busy_q <= 1'b0;
         else if (conv_start)
         begin
            busy_q <= 1'b1;
            cnt_q <= lat;
            ch_q <= conv_channel;
         end
         else if (busy_q && cnt_q <= 8'h01)
         begin
            busy_q <= 1'b0;
            conv_done <= 1'b1;
            conv_result <= {4'ha, ch_q};
         end
         else if (busy_q)
            cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule : aqs_conv_model
`default_nettype wire

// *** testbench/aqs_scheduler_tb_top.sv ***
/*
 * Self-checking bench of the two-queue scheduler: an order model of
 * expected conversions, APB master tasks and status comparisons.
 * Assumes aqs_pkg is compiled first and aqs_conv_model beside it.
 */
`timescale 1ns/1ns
`default_nettype none
`include "aqs_defs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   num_errors++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module aqs_scheduler_tb_top
   import aqs_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
   logic ext_trig1, ext_trig2, freeze, conv_start, conv_abort, conv_done;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [5:0] conv_channel, e6, c0;
   logic [9:0] conv_result;
   logic [3:0] queue_state_field;
   logic [7:0] lat;
   logic [5:0] tbl [0:63]; // Bench copy of the word table
   int exp_q[$]; // Channels expected, in order
   int num_errors, compares, cyc, starts, aborts, dones, waits, s0, d0;

   aqs_scheduler u_aqs_scheduler (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_trig1(ext_trig1), .ext_trig2(ext_trig2),
      .freeze(freeze), .conv_start(conv_start), .conv_abort(conv_abort),
      .conv_channel(conv_channel), .conv_done(conv_done),
      .conv_result(conv_result), .queue_state_field(queue_state_field));
   aqs_conv_model u_aqs_conv_model (.pclk(pclk), .presetn(presetn),
      .conv_start(conv_start), .conv_abort(conv_abort),
      .conv_channel(conv_channel), .conv_done(conv_done),
      .conv_result(conv_result), .lat(lat));

   // ****************************************
   // Clock, monitor and timeout
   // ****************************************
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // Every started conversion must be the next one the model expects
   always @(posedge pclk)
   begin
      cyc++;
      if (conv_abort === 1'b1) aborts++;
      if (conv_done === 1'b1) dones++;
      if (conv_start === 1'b1)
      begin
         starts++;
         e6 = 6'h3f;
         if (exp_q.size() > 0) e6 = 6'(exp_q.pop_front());
         `CHK("conv_channel", e6, conv_channel) // conversion order
      end
      if (cyc == 40000)
      begin
         num_errors++;
         $display("mismatch cycles exp below %0d got %0d", 40000, cyc);
         results();
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Setup cycle, then hold until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      waits = 0;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         waits++;
         @(posedge pclk);
      end
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task st(input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, `AQS_ADDR_STATUS, 32'h0);
      `CHK("status", e, rd & m)
   endtask : st
   task clr();
      apb(1'b1, `AQS_ADDR_STATUS, 32'h3f);
      s0 = starts;
   endtask : clr
   task cfg(input logic [1:0] m1, m2, input logic r, input logic [6:0] b);
      apb(1'b1, `AQS_ADDR_CTRL, {17'h0, b, 3'h0, r, m2, m1});
   endtask : cfg
   task conversion_command_word(input logic [5:0] n, input logic [5:0] ch, input logic p);
      tbl[n] = ch;
      apb(1'b1, {`AQS_PAGE_CCW, n, 2'b00}, {25'h0, p, ch});
   endtask : conversion_command_word
   task trig(input logic t1, input logic t2);
      @(posedge pclk);
      ext_trig1 <= t1; ext_trig2 <= t2;
      @(posedge pclk);
      ext_trig1 <= 1'b0; ext_trig2 <= 1'b0;
   endtask : trig
   task push(input int a, input int b);
      for (int i = a; i <= b; i++) exp_q.push_back(tbl[i]);
   endtask : push
   // Bounded waits: queue state, start count, idle with nothing owed
   task wait_qs(input logic [3:0] v);
      for (int i = 0; i < 2000 && queue_state_field !== v; i++)
         @(posedge pclk);
   endtask : wait_qs
   task wait_starts(input int n);
      for (int i = 0; i < 2000 && starts < n; i++) @(posedge pclk);
   endtask : wait_starts
   task wait_idle();
      repeat (6) @(posedge pclk);
      for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge pclk);
      wait_qs(4'h0);
   endtask : wait_idle
   task done(input string n);
      `CHK("conversions owed", 0, exp_q.size()) // queue complete
      $display("test %s done", n);
   endtask : done
   task results();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      {psel, penable, pwrite, ext_trig1, ext_trig2, freeze} = 6'h0;
      paddr = 12'h000; pwdata = 32'h0; lat = 8'h08; seed = 32'h7cbe;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `AQS_ADDR_CTRL, 32'h0);
      `CHK("ctrl reset", 32'h0, rd) // disabled after reset
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("unmapped", 1'b1, perr) // refused access
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         conversion_command_word(6'(i), (seed[5:0] % 6'd62) + 6'd1, 1'b0);
         `CHK("ccw waits", 0, waits) // no wait states
      end
      done("registers");
      // Disabled and reserved modes ignore triggers
      for (int m = 0; m < 4; m++)
      begin
         if (m == 1) continue;
         cfg(2'(m), 2'(m), 1'b0, 7'h04);
         trig(1'b1, 1'b1);
         repeat (10) @(posedge pclk);
         `CHK("inactive", 4'h0, queue_state_field) // no activity
         `CHK("no start", 0, starts) // nothing converted
      end
      done("disabled");
      // Subqueues, premature trigger, pause before end of queue
      conversion_command_word(6'd1, tbl[1], 1'b1);
      conversion_command_word(6'd3, tbl[3], 1'b1);
      cfg(2'h1, 2'h0, 1'b0, 7'h04);
      push(0, 1);
      trig(1'b1, 1'b0);
      repeat (3) @(posedge pclk);
      trig(1'b1, 1'b0);
      wait_qs(4'h8);
      `CHK("paused", 4'h8, queue_state_field) // paused code
      st(32'h15, 32'h14); // overrun with pause
      clr();
      push(2, 3);
      trig(1'b1, 1'b0);
      wait_idle();
      st(32'h15, 32'h05); // pause and completion
      done("pause");
      // End code in first word, then start pointer at word zero
      c0 = tbl[0];
      conversion_command_word(6'd0, 6'h3f, 1'b0);
      conversion_command_word(6'd1, tbl[1], 1'b0);
      conversion_command_word(6'd3, tbl[3], 1'b0);
      clr();
      trig(1'b1, 1'b0);
      wait_idle();
      st(32'h1, 32'h1); // complete, no conversion
      `CHK("no conversion", s0, starts) // nothing converted
      conversion_command_word(6'd0, c0, 1'b0);
      cfg(2'h1, 2'h0, 1'b0, 7'h00);
      clr();
      trig(1'b1, 1'b0);
      wait_idle();
      st(32'h1, 32'h1); // queue one ends at once
      `CHK("no conversion", s0, starts) // nothing converted
      done("boundaries");
      // Queue 1 aborts and suspends queue 2, restart then resume
      conversion_command_word(6'd7, 6'h3f, 1'b0);
      lat <= 8'h0c;
      for (int r = 0; r < 2; r++)
      begin
         cfg(2'h1, 2'h1, 1'(r), 7'h04);
         clr();
         d0 = aborts;
         push(4, 5);
         trig(1'b0, 1'b1);
         wait_starts(s0 + 2);
         trig(1'b1, 1'b0);
         push(0, 3);
         push(4 + r, 6);
         st(32'h7000, 32'h4000); // queue 2 suspended
         `CHK("abort", d0 + 1, aborts) // conversion aborted
         trig(1'b0, 1'b1);
         wait_idle();
         st(32'h33, 32'h23); // overrun while suspended
         done("suspend");
      end
      // Simultaneous triggers, extra queue 2 triggers while pending
      clr();
      push(0, 3);
      push(4, 6);
      trig(1'b1, 1'b1);
      repeat (3) @(posedge pclk);
      `CHK("q2 pending", 4'h7, queue_state_field) // queue 1 first
      trig(1'b0, 1'b1);
      wait_idle();
      st(32'h33, 32'h23); // overrun, queue 1 intact
      done("priority");
      // Freeze finishes the running conversion and loses triggers
      clr();
      push(0, 3);
      push(4, 6);
      trig(1'b1, 1'b0);
      trig(1'b0, 1'b1);
      wait_starts(s0 + 1);
      d0 = dones;
      freeze <= 1'b1;
      trig(1'b1, 1'b0);
      repeat (30) @(posedge pclk);
      `CHK("frozen starts", s0 + 1, starts) // no new word
      `CHK("frozen done", d0 + 1, dones) // conversion finished
      st(32'h7010, 32'h3000); // pending kept
      freeze <= 1'b0;
      wait_idle();
      done("freeze");
      // Queue 2 start pointer at the last word and beyond the table
      seed = lfsr(seed);
      conversion_command_word(6'd63, (seed[5:0] % 6'd62) + 6'd1, 1'b0);
      cfg(2'h0, 2'h1, 1'b0, 7'h3f);
      clr();
      push(63, 63);
      apb(1'b1, `AQS_ADDR_SWTRIG, 32'h2);
      wait_idle();
      st(32'h2, 32'h2); // convert then complete
      apb(1'b0, {`AQS_PAGE_RESULT, 6'd63, 2'b00}, 32'h0);
      `CHK("result", 32'h280 | 32'(tbl[63]), rd) // result kept
      cfg(2'h0, 2'h1, 1'b0, {1'b1, seed[13:8]});
      clr();
      trig(1'b0, 1'b1);
      wait_idle();
      st(32'h2, 32'h2); // complete at once
      `CHK("no conversion", s0, starts) // nothing converted
      done("pointer");
      results();
   end
endmodule : aqs_scheduler_tb_top
`default_nettype wire
